// >>> cpg_defs.vh
// constants for the coprocessor permission and secure debug register bank
`ifndef CPG_DEFS_VH
`define CPG_DEFS_VH
`define CPG_OPC1_SEL        3'h0
`define CPG_CRN_SEL         4'h1
`define CPG_CRM_PERM        4'h0
`define CPG_OPC2_PERM       3'h2
`define CPG_CRM_DBG         4'h1
`define CPG_OPC2_DBG        3'h1
`define CPG_SIMD_BIT        31
`define CPG_UPPER_BIT       30
`define CPG_C11_HI          23
`define CPG_C11_LO          22
`define CPG_C10_HI          21
`define CPG_C10_LO          20
`define CPG_DBG_NONINV_BIT  1
`define CPG_DBG_INV_BIT     0
`define CPG_PERM_DENIED     2'h0
`define CPG_PERM_PRIV       2'h1
`define CPG_PERM_RSVD       2'h2
`define CPG_PERM_FULL       2'h3
`define CPG_NUM_DEBUG_CP    4'hE
`define CPG_NUM_SYSCTL_CP   4'hF
`define CPG_NUM_COPROC_TEN_PERMISSION        4'hA
`define CPG_NUM_COPROC_ELEVEN_PERMISSION        4'hB
`define CPG_ZERO32          32'h00000000
`endif

// >>> cpg_perm_check.v
// permission decode for one floating point coprocessor field
`timescale 1ns/10ps
`include "cpg_defs.vh"
module cpg_perm_check (
  input  wire [1:0] field,
  input  wire       privileged,
  input  wire       secure,
  input  wire       ns_gate,
  output wire       allowed
);
  wire mode_ok;
  assign mode_ok = (field == `CPG_PERM_FULL) ||
                   ((field == `CPG_PERM_PRIV) && privileged);  // see RQ7 see RQ8 see RQ23
  assign allowed = mode_ok && (secure || ns_gate);  // see RQ10
endmodule

// >>> cpg_regs.v
// coprocessor permission control and secure user debug permit registers
//
// Function
// RQ1: permission register privileged only, one shared copy
// RQ2: debug and system coprocessors never gated here
// RQ3: simd disable makes simd-only instructions undefined
// RQ4: upper disable makes D16-D31 instructions undefined
// RQ5: float-only build: both disable bits read one
// RQ6: no float build: disable bits unknown, write zero
// RQ7: field codes: 01 privileged, 10 reserved, 11 all
// RQ8: fields reset denied; denied use is undefined
// RQ9: absent coprocessor field keeps reading 00
// RQ10: non-secure use needs non-secure gate bit
// RQ11: field access governed by its non-secure gate bit
// RQ12: permission register at 0, c1, c0, 2
// RQ13: software issues barrier after permission update
// RQ14: software enables both coprocessors before system registers
// RQ15: debug permit register secure privileged only
// RQ16: bit 1 permits secure user non-invasive debug
// RQ17: bit 0 permits secure user invasive debug
// RQ18: debug permit register at 0, c1, c1, 1
// RQ19: non-secure simd lockout forces simd disable one
// RQ20: non-secure upper lockout forces upper disable one
// RQ21: gate bits 11/10 allow non-secure access
// RQ22: unused bits read zero, ignore writes
// RQ23: reserved code 10 behaves as denied
`timescale 1ns/10ps
`include "cpg_defs.vh"
module cpg_regs #(
  parameter HAS_FLOAT = 1,
  parameter HAS_SIMD  = 1
) (
  input  wire        clk,
  input  wire        rstn,
  input  wire        mv_valid,
  input  wire        mv_write,
  input  wire [2:0]  mv_opc1,
  input  wire [3:0]  mv_crn,
  input  wire [3:0]  mv_crm,
  input  wire [2:0]  mv_opc2,
  input  wire [31:0] mv_wdata,
  input  wire        cpu_privileged,
  input  wire        cpu_secure,
  input  wire        nonsecure_gate_coproc_ten_permission,
  input  wire        nonsecure_gate_coproc_eleven_permission,
  input  wire        nonsecure_simd_lockout,
  input  wire        nonsecure_upper_fp_lockout,
  input  wire        insn_valid,
  input  wire [3:0]  insn_coproc,
  input  wire        insn_simd_only,
  input  wire        insn_upper_regs,
  output reg  [31:0] mv_rdata,
  output wire        mv_hit,
  output wire        mv_undef,
  output wire        insn_undef,
  output wire        secure_user_noninvasive_debug,
  output wire        secure_user_invasive_debug
);
  reg        simd_only_disable_q;
  reg        upper_fp_regs_disable_q;
  reg  [1:0] coproc_ten_permission_q;
  reg  [1:0] coproc_eleven_permission_q;
  reg        dbg_noninv_q;
  reg        dbg_inv_q;
  wire       sel_perm;
  wire       sel_dbg;
  wire       perm_ok;
  wire       dbg_ok;
  wire       wr_perm;
  wire       wr_dbg;
  wire       simd_view;
  wire       upper_view;
  wire       simd_forced;
  wire       upper_forced;
  wire       c10_allowed;
  wire       c11_allowed;
  wire       cp_allowed;
  wire       simd_block;
  wire       upper_block;
  wire       fp_present;

  function sel_match;
    input [3:0] crm;
    input [2:0] opc2;
    begin
      sel_match = mv_valid && (mv_opc1 == `CPG_OPC1_SEL) && (mv_crn == `CPG_CRN_SEL) &&
                  (mv_crm == crm) && (mv_opc2 == opc2);
    end
  endfunction

  assign fp_present = (HAS_FLOAT != 0);
  assign sel_perm   = sel_match(`CPG_CRM_PERM, `CPG_OPC2_PERM);  // see RQ12
  assign sel_dbg    = sel_match(`CPG_CRM_DBG, `CPG_OPC2_DBG);  // see RQ18
  assign perm_ok    = cpu_privileged;  // see RQ1
  assign dbg_ok     = cpu_privileged && cpu_secure;  // see RQ15
  assign mv_hit     = sel_perm || sel_dbg;
  assign mv_undef   = (sel_perm && !perm_ok) || (sel_dbg && !dbg_ok);
  assign wr_perm    = sel_perm && perm_ok && mv_write;
  assign wr_dbg     = sel_dbg && dbg_ok && mv_write;

  // float-only build ties both disable bits high
  assign simd_forced  = fp_present && (HAS_SIMD == 0);  // see RQ5
  assign upper_forced = simd_forced;  // see RQ5
  // lockouts only act while running non-secure
  assign simd_view  = simd_forced || simd_only_disable_q ||
                      (!cpu_secure && nonsecure_simd_lockout);  // see RQ19
  assign upper_view = upper_forced || upper_fp_regs_disable_q ||
                      (!cpu_secure && nonsecure_upper_fp_lockout);  // see RQ20

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      simd_only_disable_q        <= 1'b0;
      upper_fp_regs_disable_q    <= 1'b0;
      coproc_ten_permission_q    <= `CPG_PERM_DENIED;  // see RQ8
      coproc_eleven_permission_q <= `CPG_PERM_DENIED;  // see RQ8
      dbg_noninv_q               <= 1'b0;  // see RQ16
      dbg_inv_q                  <= 1'b0;  // see RQ17
    end else begin
      if (wr_perm) begin
        // without float hardware the bits are kept at zero, writes should be zero
        if (fp_present && !simd_forced && !(!cpu_secure && nonsecure_simd_lockout)) begin
          simd_only_disable_q <= mv_wdata[`CPG_SIMD_BIT];  // see RQ3 see RQ6 see RQ19
        end
        if (fp_present && !upper_forced && !(!cpu_secure && nonsecure_upper_fp_lockout)) begin
          upper_fp_regs_disable_q <= mv_wdata[`CPG_UPPER_BIT];  // see RQ4 see RQ6 see RQ20
        end
        // absent coprocessors keep reading denied
        if (fp_present && (cpu_secure || nonsecure_gate_coproc_ten_permission)) begin
          coproc_ten_permission_q <= mv_wdata[`CPG_C10_HI:`CPG_C10_LO];  // see RQ9 see RQ11
        end
        if (fp_present && (cpu_secure || nonsecure_gate_coproc_eleven_permission)) begin
          coproc_eleven_permission_q <= mv_wdata[`CPG_C11_HI:`CPG_C11_LO];  // see RQ9 see RQ11
        end
      end
      if (wr_dbg) begin
        dbg_noninv_q <= mv_wdata[`CPG_DBG_NONINV_BIT];  // see RQ16
        dbg_inv_q    <= mv_wdata[`CPG_DBG_INV_BIT];  // see RQ17
      end
    end
  end

  always @* begin
    mv_rdata = `CPG_ZERO32;  // see RQ22
    if (sel_perm && perm_ok) begin
      mv_rdata[`CPG_SIMD_BIT]  = simd_view;
      mv_rdata[`CPG_UPPER_BIT] = upper_view;
      // non-secure reads of an ungated field show zero
      if (cpu_secure || nonsecure_gate_coproc_eleven_permission) begin
        mv_rdata[`CPG_C11_HI:`CPG_C11_LO] = coproc_eleven_permission_q;  // see RQ11
      end
      if (cpu_secure || nonsecure_gate_coproc_ten_permission) begin
        mv_rdata[`CPG_C10_HI:`CPG_C10_LO] = coproc_ten_permission_q;  // see RQ11
      end
    end else if (sel_dbg && dbg_ok) begin
      mv_rdata[`CPG_DBG_NONINV_BIT] = dbg_noninv_q;
      mv_rdata[`CPG_DBG_INV_BIT]    = dbg_inv_q;
    end
  end

  cpg_perm_check u_chk10 (
    .field      (coproc_ten_permission_q),
    .privileged (cpu_privileged),
    .secure     (cpu_secure),
    .ns_gate    (nonsecure_gate_coproc_ten_permission),  // see RQ21
    .allowed    (c10_allowed)
  );

  cpg_perm_check u_chk11 (
    .field      (coproc_eleven_permission_q),
    .privileged (cpu_privileged),
    .secure     (cpu_secure),
    .ns_gate    (nonsecure_gate_coproc_eleven_permission),  // see RQ21
    .allowed    (c11_allowed)
  );

  // only coprocessors 10 and 11 are gated; 14 and 15 pass untouched
  assign cp_allowed  = (insn_coproc == `CPG_NUM_COPROC_TEN_PERMISSION) ? c10_allowed :
                       (insn_coproc == `CPG_NUM_COPROC_ELEVEN_PERMISSION) ? c11_allowed : 1'b1;  // see RQ2
  assign simd_block  = insn_simd_only && simd_view;  // see RQ3
  assign upper_block = insn_upper_regs && upper_view;  // see RQ4
  assign insn_undef  = insn_valid && (!cp_allowed ||
                       (((insn_coproc == `CPG_NUM_COPROC_TEN_PERMISSION) || (insn_coproc == `CPG_NUM_COPROC_ELEVEN_PERMISSION)) &&
                        (simd_block || upper_block)));  // see RQ8 see RQ10

  assign secure_user_noninvasive_debug = dbg_noninv_q;  // see RQ16
  assign secure_user_invasive_debug    = dbg_inv_q;  // see RQ17
endmodule

// >>> cpg_pipe_model.sv
// pipeline model issuing coprocessor moves to the register bank
`timescale 1ns/10ps
module cpg_pipe_model (
  input  wire        clk,
  input  wire [31:0] mv_rdata,
  input  wire        mv_undef,
  output reg         mv_valid,
  output reg         mv_write,
  output reg  [3:0]  mv_crm,
  output reg  [2:0]  mv_opc2,
  output reg  [31:0] mv_wdata,
  output reg         cpu_privileged,
  output reg         cpu_secure
);
  initial begin
    {mv_valid, mv_write, mv_crm, mv_opc2, mv_wdata} = 40'h0;
    {cpu_privileged, cpu_secure} = 2'h3;
  end
  // one move, then an idle cycle as barrier; data inverted once released
  task mv(input w, input [3:0] crm, input [2:0] o2, input [31:0] d, input p,
          input s, output [31:0] rd, output ud);
    @(posedge clk);
    {mv_valid, mv_write, mv_crm, mv_opc2, mv_wdata} <= {1'b1, w, crm, o2, d};
    {cpu_privileged, cpu_secure} <= {p, s};
    #25;
    rd = mv_rdata;
    ud = mv_undef;
    @(posedge clk);
    mv_valid <= 1'b0;
    mv_wdata <= ~d;
  endtask
endmodule

// >>> cpg_regs_monitor.sv
// assertion checker for the coprocessor permission register bank
`timescale 1ns/10ps
module cpg_regs_monitor (
  input wire        clk,
  input wire        rstn,
  input wire        mv_valid,
  input wire        mv_write,
  input wire [2:0]  mv_opc1,
  input wire [3:0]  mv_crn,
  input wire [3:0]  mv_crm,
  input wire [2:0]  mv_opc2,
  input wire [31:0] mv_wdata,
  input wire        cpu_privileged,
  input wire        cpu_secure,
  input wire        nonsecure_gate_coproc_ten_permission,
  input wire        insn_valid,
  input wire [3:0]  insn_coproc,
  input wire [31:0] mv_rdata,
  input wire        mv_hit,
  input wire        mv_undef,
  input wire        insn_undef,
  input wire        secure_user_noninvasive_debug,
  input wire        secure_user_invasive_debug
);
  wire sel  = mv_valid && mv_opc1 == 3'h0 && mv_crn == 4'h1;
  wire perm = sel && mv_crm == 4'h0 && mv_opc2 == 3'h2;
  wire dbg  = sel && mv_crm == 4'h1 && mv_opc2 == 3'h1;
  wire dwr  = dbg && mv_write && cpu_privileged && cpu_secure;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_perm_hit; perm |-> mv_hit; endproperty
  a_perm_hit: assert property (p_perm_hit) else $error("perm move missed");
  property p_dbg_hit; dbg |-> mv_hit; endproperty
  a_dbg_hit: assert property (p_dbg_hit) else $error("debug move missed");
  property p_user; perm && !cpu_privileged |-> mv_undef && mv_rdata == 32'h0; endproperty
  a_user: assert property (p_user) else $error("user perm access");
  property p_ns_dbg; dbg && !cpu_secure |-> mv_undef; endproperty
  a_ns_dbg: assert property (p_ns_dbg) else $error("nonsecure debug access");
  property p_inv; dwr |=> secure_user_invasive_debug == $past(mv_wdata[0]); endproperty
  a_inv: assert property (p_inv) else $error("invasive bit");
  property p_ninv; dwr |=> secure_user_noninvasive_debug == $past(mv_wdata[1]); endproperty
  a_ninv: assert property (p_ninv) else $error("noninvasive bit");
  property p_hold; !dwr |=> $stable({secure_user_noninvasive_debug,
    secure_user_invasive_debug}); endproperty
  a_hold: assert property (p_hold) else $error("debug bits moved");
  property p_raz; perm && !mv_write && !mv_undef |->
    mv_rdata[29:24] == 6'h0 && mv_rdata[19:0] == 20'h0; endproperty
  a_raz: assert property (p_raz) else $error("unused bits set");
  property p_cpf; insn_valid && insn_coproc >= 4'hE |-> !insn_undef; endproperty
  a_cpf: assert property (p_cpf) else $error("debug_coprocessor/15 gated");
  property p_nsg; insn_valid && insn_coproc == 4'hA && !cpu_secure &&
    !nonsecure_gate_coproc_ten_permission |-> insn_undef; endproperty
  a_nsg: assert property (p_nsg) else $error("nonsecure coproc_ten_permission allowed");
  c_perm: cover property (perm && mv_write && !mv_undef);
  c_dwr: cover property (dwr);
  c_undef: cover property (insn_valid && insn_undef);
endmodule
bind cpg_regs cpg_regs_monitor i_cpg_regs_monitor (.clk, .rstn, .mv_valid, .mv_write,
  .mv_opc1, .mv_crn, .mv_crm, .mv_opc2, .mv_wdata, .cpu_privileged, .cpu_secure,
  .nonsecure_gate_coproc_ten_permission, .insn_valid, .insn_coproc, .mv_rdata, .mv_hit, .mv_undef,
  .insn_undef, .secure_user_noninvasive_debug, .secure_user_invasive_debug);

// >>> cpg_regs_bench.sv
// self-checking bench for the coprocessor permission register bank
`timescale 1ns/10ps
module cpg_regs_bench;
  typedef struct packed {logic w; logic [3:0] c; logic [2:0] o; logic [31:0] d;
    logic p; logic s; logic [31:0] x; logic u;} cpg_row_t;
  reg clk = 1'b0, rstn = 1'b0, nonsecure_gate_coproc_ten_permission = 1'b0, nonsecure_gate_coproc_eleven_permission = 1'b0;
  reg nonsecure_simd_lockout = 1'b0, nonsecure_upper_fp_lockout = 1'b0, insn_valid = 1'b0;
  reg insn_simd_only = 1'b0, insn_upper_regs = 1'b0, ud;
  reg [3:0] insn_coproc = 4'h0;
  reg [31:0] rd;
  wire mv_valid, mv_write, cpu_privileged, cpu_secure, mv_hit, mv_undef, insn_undef;
  wire secure_user_noninvasive_debug, secure_user_invasive_debug;
  wire [3:0] mv_crm;
  wire [2:0] mv_opc2;
  wire [31:0] mv_wdata, mv_rdata;
  integer err_total = 0, compares = 0, i;
  cpg_row_t rows [0:9] = '{'{0,0,2,0,1,1,0,0}, '{1,0,2,32'hFFFFFFFF,1,1,0,0},
    '{0,0,2,0,1,1,32'hC0F00000,0}, '{1,0,2,32'h00A00000,1,1,32'hC0F00000,0},
    '{0,0,2,0,1,1,32'h00A00000,0}, '{0,0,2,0,0,1,0,1}, '{1,1,1,3,1,1,0,0},
    '{0,1,1,0,1,1,3,0}, '{0,1,1,0,1,0,0,1}, '{0,1,1,0,0,1,0,1}};
  cpg_pipe_model i_cpg_pipe_model (.clk, .mv_rdata, .mv_undef, .mv_valid, .mv_write,
    .mv_crm, .mv_opc2, .mv_wdata, .cpu_privileged, .cpu_secure);
  cpg_regs i_cpg_regs (.clk, .rstn, .mv_valid, .mv_write, .mv_opc1(3'h0), .mv_crn(4'h1),
    .mv_crm, .mv_opc2, .mv_wdata, .cpu_privileged, .cpu_secure, .nonsecure_gate_coproc_ten_permission,
    .nonsecure_gate_coproc_eleven_permission, .nonsecure_simd_lockout, .nonsecure_upper_fp_lockout,
    .insn_valid, .insn_coproc, .insn_simd_only, .insn_upper_regs, .mv_rdata, .mv_hit,
    .mv_undef, .insn_undef, .secure_user_noninvasive_debug, .secure_user_invasive_debug);
  task chk(input [32:0] g, input [32:0] e);
    compares = compares + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task mvc(input w, input [2:0] o, input [31:0] d, input s, input [32:0] e);
    i_cpg_pipe_model.mv(w, o == 3'h2 ? 4'h0 : 4'h1, o, d, 1'b1, s, rd, ud);
    chk({rd, ud}, e);
  endtask
  task ic(input [3:0] cp, input so, input up, input e);
    @(posedge clk);
    {insn_valid, insn_coproc, insn_simd_only, insn_upper_regs} <= {1'b1, cp, so, up};
    #25 chk({32'h0, insn_undef}, {32'h0, e});
    @(posedge clk) insn_valid <= 1'b0;
  endtask
  task test_done;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial forever #25 clk = ~clk;
  initial begin
    #100000 err_total = err_total + 1;
    test_done;
  end
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    for (i = 0; i < 10; i = i + 1) begin
      i_cpg_pipe_model.mv(rows[i].w, rows[i].c, rows[i].o, rows[i].d, rows[i].p,
        rows[i].s, rd, ud);
      chk({rd, ud}, {rows[i].x, rows[i].u});
    end
    chk({31'h0, secure_user_noninvasive_debug, secure_user_invasive_debug}, 33'h3);
    $display("row test done");
    mvc(0, 2, 0, 1, {32'h00A00000, 1'b0});
    ic(4'hA, 0, 0, 1);
    ic(4'hE, 0, 0, 0);
    mvc(1, 2, 32'hC0F00000, 1, {32'h00A00000, 1'b0});
    ic(4'hA, 1, 0, 1);
    ic(4'hA, 0, 1, 1);
    ic(4'hB, 0, 0, 0);
    mvc(1, 2, 32'h00F00000, 1, {32'hC0F00000, 1'b0});
    @(posedge clk) {nonsecure_simd_lockout, nonsecure_upper_fp_lockout} <= 2'h3;
    mvc(0, 2, 0, 0, {32'hC0000000, 1'b0});
    ic(4'hA, 0, 0, 1);
    @(posedge clk) {nonsecure_gate_coproc_eleven_permission, nonsecure_gate_coproc_ten_permission} <= 2'h2;
    mvc(0, 2, 0, 0, {32'hC0C00000, 1'b0});
    @(posedge clk) nonsecure_gate_coproc_ten_permission <= 1'b1;
    ic(4'hA, 0, 0, 0);
    $display("secure state test done");
    @(posedge clk) rstn <= 1'b0;
    #75 chk({31'h0, secure_user_noninvasive_debug, secure_user_invasive_debug}, 0);
    @(posedge clk) rstn <= 1'b1;
    mvc(0, 2, 0, 1, 0);
    $display("reset test done");
    test_done;
  end
endmodule
